// file: src/pwm_fine_step_pkg.sv
package pwm_fine_step_pkg;

  // Modulation counter geometry
  localparam int CNT_W   = 6;
  localparam int CYC_W   = 4;
  localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3f;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  // Channel weight register layout
  localparam int WGT_RSV_BIT = 7;
  localparam int WGT_POL_BIT = 6;
  localparam int WGT_MSB     = 5;
  localparam int NUM_CH      = 2;

  // Register word indices (byte address = index * 4)
  localparam logic [1:0] IDX_WEIGHT_A = 2'h0;
  localparam logic [1:0] IDX_WEIGHT_B = 2'h1;
  localparam logic [1:0] IDX_FINE     = 2'h2;
  localparam logic [1:0] IDX_STATUS   = 2'h3;

  // Reset values: reserved bit set, zero width, no fine steps
  localparam logic [7:0] WEIGHT_RST = 8'h80;
  localparam logic [7:0] FINE_RST   = 8'h00;
  localparam logic [7:0] RSV_MASK   = 8'h80;

  typedef struct packed {
    logic [7:0] weightA;
    logic [7:0] weightB;
    logic [7:0] fine;
  } regset_s;

  typedef struct packed {
    logic [1:0]  addr;
    logic        read;
    logic        write;
    logic [31:0] wdata;
  } avl_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic        waitreq;
  } avl_rsp_s;

  // Fine-step cycle selection for one nibble and one cycle index
  function automatic logic fineSel(input logic [3:0] bits,
                                   input logic [3:0] cyc);
    fineSel = (bits[0] && cyc == 4'h8)
           || (bits[1] && cyc[2:0] == 3'h4)
           || (bits[2] && cyc[1:0] == 2'h2)
           || (bits[3] && cyc[0]);
  endfunction

endpackage

// file: src/pwm_channel.sv
`timescale 1ns/1ns
module pwm_channel
  import pwm_fine_step_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Shared timing
  input  wire logic [CNT_W-1:0] count,
  input  wire logic [CYC_W-1:0] cycle,
  // Latched settings
  input  wire logic [WGT_MSB:0] width,
  input  wire logic             polarity,
  input  wire logic [3:0]       fineBits,
  // Pin
  output logic                  pwmOut
);

  typedef struct packed {
    logic active;
    logic pin;
  } chan_s;

  chan_s st_q;
  chan_s st_d;
  logic  extraNext;

  always_comb begin
    st_d      = st_q;
    // Index advances at the wrap, so look one cycle ahead
    extraNext = fineSel(fineBits, cycle + 4'h1);
    if (count == CNT_MAX) begin
      st_d.active = 1'b1;
    end
    // Stop beats start: zero width gives no base pulse
    if (count == width - 6'h01) begin
      st_d.active = 1'b0;
    end
    // Extra clock leads the pulse and beats a stop on the same count
    if (extraNext && count == CNT_MAX - 6'h01) begin
      st_d.active = 1'b1;
    end
    st_d.pin = st_d.active ^ polarity;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pwmOut = st_q.pin;

endmodule

// file: src/pwm_fine_step_dac_generator.sv
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
// Contract
// - One modulation counter advances every clock, never stopping.
// - At each wrap of the low six counter bits every channel with nonzero width goes active.
// - When the count matches a channel weight the output goes inactive.
// - Weight bit 6 inverts the output polarity of its channel.
// - Weight bit 7 is reserved and always reads one.
// - Weight bits 5:0 hold the unsigned base pulse width.
// - Selected cycles get one extra clock of pulse, others stay unchanged.
// - Fine nibble bits select cycles 8; 4,12; 2,6,10,14; all odd; never 0.
// - Several fine bits widen the pulse in the union of their cycles.
// - The extra clock sits at the start of the pulse, not the end.
// - One fine register serves a pair; upper nibble high, lower low channel.
// - Weight and fine bits together form one ten-bit channel value.
module pwm_fine_step_dac_generator
  import pwm_fine_step_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [1:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  // Channel pins toward the RC filters
  output logic [NUM_CH-1:0] pwmOut
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CYC_W-1:0] cycle;
    regset_s          shadow;
    regset_s          live;
    logic             busy;
    avl_rsp_s         rsp;
  } top_s;

  top_s st_q;
  top_s st_d;

  logic [NUM_CH-1:0] chanPin;
  logic              wrap;

  // Combined ten-bit value of a channel, as software sees it
  function automatic logic [9:0] dacValue(input logic [7:0] w,
                                          input logic [3:0] f);
    dacValue = {w[WGT_MSB:0], f};
  endfunction

  function automatic logic [7:0] wgtWrite(input logic [7:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
    wgtWrite = be[0] ? (d[7:0] | RSV_MASK) : old;
  endfunction

  always_comb begin
    st_d = st_q;
    wrap = (st_q.count == CNT_MAX);
    st_d.count = st_q.count + 6'h01;
    if (wrap) begin
      st_d.cycle = st_q.cycle + 4'h1;
      st_d.live  = st_q.shadow;
    end

    // One wait cycle per access, answered from a register
    st_d.rsp.waitreq = 1'b1;
    st_d.busy        = 1'b0;
    if ((avsRead || avsWrite) && !st_q.busy) begin
      st_d.busy        = 1'b1;
      st_d.rsp.waitreq = 1'b0;
      st_d.rsp.rdata   = 32'h0000_0000;
      if (avsWrite) begin
        unique case (avsAddress)
          IDX_WEIGHT_A: st_d.shadow.weightA =
            wgtWrite(st_q.shadow.weightA, avsWriteData, avsByteEnable);
          IDX_WEIGHT_B: st_d.shadow.weightB =
            wgtWrite(st_q.shadow.weightB, avsWriteData, avsByteEnable);
          IDX_FINE: if (avsByteEnable[0]) begin
            st_d.shadow.fine = avsWriteData[7:0];
          end
          IDX_STATUS: ;
        endcase
      end else begin
        unique case (avsAddress)
          IDX_WEIGHT_A: st_d.rsp.rdata = {24'h0, st_q.shadow.weightA};
          IDX_WEIGHT_B: st_d.rsp.rdata = {24'h0, st_q.shadow.weightB};
          IDX_FINE:     st_d.rsp.rdata = {24'h0, st_q.shadow.fine};
          IDX_STATUS:   st_d.rsp.rdata = {
            2'h0, dacValue(st_q.live.weightB, st_q.live.fine[7:4]),
            dacValue(st_q.live.weightA, st_q.live.fine[3:0]),
            st_q.cycle, st_q.count};
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '{count:   CNT_ZERO,
                cycle:   '0,
                shadow:  '{WEIGHT_RST, WEIGHT_RST, FINE_RST},
                live:    '{WEIGHT_RST, WEIGHT_RST, FINE_RST},
                busy:    1'b0,
                rsp:     '{32'h0000_0000, 1'b1}};
    end else begin
      st_q <= st_d;
    end
  end

  // Lower channel on the low nibble, higher channel on the high nibble
  pwm_channel u_chanA (
    .mclk     (mclk),
    .rst      (rst),
    .count    (st_q.count),
    .cycle    (st_q.cycle),
    .width    (st_q.live.weightA[WGT_MSB:0]),
    .polarity (st_q.live.weightA[WGT_POL_BIT]),
    .fineBits (st_q.live.fine[3:0]),
    .pwmOut   (chanPin[0])
  );

  pwm_channel u_chanB (
    .mclk     (mclk),
    .rst      (rst),
    .count    (st_q.count),
    .cycle    (st_q.cycle),
    .width    (st_q.live.weightB[WGT_MSB:0]),
    .polarity (st_q.live.weightB[WGT_POL_BIT]),
    .fineBits (st_q.live.fine[7:4]),
    .pwmOut   (chanPin[1])
  );

  assign pwmOut         = chanPin;
  assign avsReadData    = st_q.rsp.rdata;
  assign avsWaitRequest = st_q.rsp.waitreq;

endmodule

// file: verification/rc_filter_model.sv
`timescale 1ns/1ns
module rc_filter_model (
  // Clock
  input wire logic        mclk,
  // Pin and filtered level
  input wire logic        pin,
  output logic     [15:0] level
);
  // Shift of 8: time constant well above one 64-clock cycle
  initial level = 16'h0000;
  always @(posedge mclk) begin
    if (pin === 1'b1) level <= level + ((16'hffff - level) >> 8);
    else level <= level - (level >> 8);
  end
endmodule

// file: verification/pwm_fine_step_dac_generator_sva.sv
`timescale 1ns/1ns
module pwm_fine_step_dac_generator_sva
  import pwm_fine_step_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // Bus
  input wire logic [1:0]        avsAddress,
  input wire logic              avsRead,
  input wire logic              avsWrite,
  input wire logic [31:0]       avsWriteData,
  input wire logic [3:0]        avsByteEnable,
  input wire logic [31:0]       avsReadData,
  input wire logic              avsWaitRequest,
  // Pins
  input wire logic [NUM_CH-1:0] pwmOut
);
  logic [9:0] ticks_q;
  logic [9:0] offs_q;
  logic       seen_q;
  logic       stat;
  assign stat = !avsWaitRequest && avsRead && avsAddress == IDX_STATUS;
  // Status phase is unknown, so learn it at the first status read
  always_ff @(posedge mclk) begin
    ticks_q <= rst ? 10'h000 : ticks_q + 10'h001;
    seen_q <= !rst && (seen_q || stat);
    if (stat && !seen_q)
      offs_q <= avsReadData[9:0] - ticks_q;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence askS; (avsRead || avsWrite) && avsWaitRequest; endsequence
  sequence answerS; !avsWaitRequest ##1 avsWaitRequest; endsequence
  wait_one_a: assert property ($fell(avsWaitRequest) |-> answerS)
    else $error("waitrequest low too long");
  answer_prompt_a: assert property (askS |=> answerS)
    else $error("access not answered after one wait");
  idle_wait_a: assert property (!avsRead && !avsWrite |=> avsWaitRequest)
    else $error("answer without request");
  reserved_bit_a: assert property (stat == 1'b0 && !avsWaitRequest
    && avsRead && avsAddress < IDX_FINE |-> avsReadData[WGT_RSV_BIT])
    else $error("reserved weight bit read as zero");
  data_hold_a: assert property (avsWaitRequest && $past(avsWaitRequest)
    |-> $stable(avsReadData)) else $error("read data moved");
  count_free_a: assert property (stat && seen_q |->
    avsReadData[5:0] - ticks_q[5:0] == offs_q[5:0])
    else $error("counter skipped or stalled");
  cycle_index_a: assert property (stat && seen_q |->
    avsReadData[9:0] - ticks_q == offs_q) else $error("cycle index wrong");
  reset_pins_a: assert property (disable iff (1'b0) rst |=> pwmOut == '0)
    else $error("pins not cleared by reset");
endmodule
bind pwm_fine_step_dac_generator pwm_fine_step_dac_generator_sva sva_inst (
  .mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .pwmOut(pwmOut),
  .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest));

// file: verification/pwm_fine_step_dac_generator_tb.sv
`timescale 1ns/1ns
module pwm_fine_step_dac_generator_tb import pwm_fine_step_pkg::*;;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              avsRead = 1'b0;
  logic              avsWrite = 1'b0;
  logic [1:0]        avsAddress = 2'h0;
  logic [31:0]       avsWriteData = 32'h0;
  logic [3:0]        avsByteEnable = 4'hf;
  logic [31:0]       avsReadData;
  logic              avsWaitRequest;
  logic [NUM_CH-1:0] pwmOut;
  logic [31:0]       lvl;
  logic [31:0]       rd;
  int                fails = 0;
  int                checked = 0;
  always #20 mclk = ~mclk;
  pwm_fine_step_dac_generator pwm_fine_step_dac_generator_inst (
    .mclk(mclk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .pwmOut(pwmOut),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest));
  rc_filter_model rc_filter_model_inst [1:0] (
    .mclk(mclk), .pin(pwmOut), .level(lvl));
  task check(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task access(input logic wr, input logic [1:0] a, input logic [7:0] d,
              input logic [3:0] be);
    @(posedge mclk);
    avsRead <= !wr;
    avsWrite <= wr;
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsByteEnable <= be;
    do begin
      @(posedge mclk);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  // One full 1024-clock period holds every cycle index once
  task setCheck(input logic [7:0] wa, wb, f, input logic [10:0] ea, eb);
    logic [10:0] a, b;
    access(1'b1, IDX_WEIGHT_A, wa, 4'hf);
    access(1'b1, IDX_WEIGHT_B, wb, 4'hf);
    access(1'b1, IDX_FINE, f, 4'hf);
    a = 0;
    b = 0;
    repeat (1100) @(posedge mclk);
    repeat (1024) begin
      @(posedge mclk);
      a += pwmOut[0];
      b += pwmOut[1];
    end
    check(a, ea);
    check(b, eb);
    access(1'b0, IDX_STATUS, 8'h00, 4'hf);
    check(11'(rd[19:10]), 11'({wa[5:0], f[3:0]}));
    check(11'(rd[29:20]), 11'({wb[5:0], f[7:4]}));
  endtask
  task testReset;
    access(1'b0, IDX_WEIGHT_A, 8'h00, 4'hf);
    check(rd[7:0], WEIGHT_RST);
    access(1'b0, IDX_WEIGHT_B, 8'h00, 4'hf);
    check(rd[7:0], WEIGHT_RST);
    access(1'b0, IDX_FINE, 8'h00, 4'hf);
    check(rd[7:0], FINE_RST);
  endtask
  task testRegs;
    access(1'b1, IDX_WEIGHT_A, 8'h05, 4'hf);
    access(1'b1, IDX_WEIGHT_A, 8'h3a, 4'he);
    access(1'b0, IDX_WEIGHT_A, 8'h00, 4'hf);
    check(rd[7:0], 8'h85);
    access(1'b1, IDX_FINE, 8'ha5, 4'hf);
    access(1'b0, IDX_FINE, 8'h00, 4'hf);
    check(rd[7:0], 8'ha5);
    access(1'b1, IDX_STATUS, 8'hff, 4'hf);
    access(1'b0, IDX_STATUS, 8'h00, 4'hf);
    access(1'b0, IDX_STATUS, 8'h00, 4'hf);
  endtask
  task testFine;
    int hi;
    for (int k = 0; k < 4; k++)
      setCheck(8'h0a, 8'h21, 8'((1 << k) | ((8 >> k) << 4)),
               11'(160 + (1 << k)), 11'(528 + (8 >> k)));
    setCheck(8'h3e, 8'h00, 8'hff, 11'd1007, 11'd15);
    // Status read just done gives the counter phase; a zero-width
    // channel with fine bits may only pulse on the last count
    hi = 0;
    for (int t = 1; t <= 128; t++) begin
      @(posedge mclk);
      if (pwmOut[1] === 1'b1) hi = (rd[5:0] + 1 + t) % 64;
    end
    check(11'(hi), 11'd63);
  endtask
  task testPol;
    setCheck(8'h80, 8'hbf, 8'h00, 11'd0, 11'd1008);
    setCheck(8'hc5, 8'h81, 8'h00, 11'd944, 11'd16);
    check(11'(lvl[15:0] > lvl[31:16]), 11'd1);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    testReset;
    testRegs;
    testFine;
    testPol;
    results;
  end
  initial begin
    #1600000;
    check(1'b1, 1'b0);
    results;
  end
endmodule
